// ==== verilog/fault_event_recorder.sv ====
// fault waveform and event recorder with front-panel key handling
// assumes converter and keypad are asynchronous; event, trip and readout
// requests come from logic on clk_i
//
// Overview of operation
// R01 - a converter sample is requested 32 times per power cycle.
// R02 - every sample is carried and stored as a 16 bit word.
// R03 - a trip captures 50 cycles, 45 before the trigger and 5 after it; a trip right after a capture gets a short pre window.
// R04 - the newest 200 records are kept, the oldest overwritten first; once 200 are held, live samples overwrite the oldest's waveform.
// R05 - each record stores the fault parameter with its time stamp.
// R06 - up to 5000 events are logged, each stamped to 1 ms.
// R07 - trips, supervision, pickup, reset, breaker, input, setting and error events are logged.
// R08 - any key lights the backlight for a settable time.
// R09 - the menu key in the tripped state returns the relay to normal.
// R10 - in setting mode increment raises and decrement lowers the setting.
// R11 - records are read through a front and a rear readout port.
// R12 - a full event log overwrites its oldest entry.
`timescale 1ns/1ps
module fault_event_recorder #(
    parameter int unsigned SAMPLE_CYC = rec_pkg::SAMPLE_CYC,
    parameter int unsigned STAMP_CYC  = rec_pkg::STAMP_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    output logic                            sample_req_o,
    input  wire logic                       adc_valid_i,
    input  wire logic [rec_pkg::SMP_W-1:0]  adc_data_i,
    input  wire logic [rec_pkg::EV_N-1:0]   event_i,
    input  wire logic [rec_pkg::SMP_W-1:0]  fault_param_i,
    input  wire logic                       time_load_i,
    input  wire logic [rec_pkg::TS_W-1:0]   time_value_i,
    input  wire logic [rec_pkg::KEY_N-1:0]  key_i,
    input  wire logic [rec_pkg::BL_W-1:0]   backlight_time_i,
    input  wire logic [1:0]                 rd_req_i,
    input  wire logic [rec_pkg::RIDX_W-1:0] rd_rec_i,
    input  wire logic [rec_pkg::SIDX_W-1:0] rd_idx_i,
    output logic [1:0]                      rd_valid_o,
    output logic [rec_pkg::SMP_W-1:0]       rd_data_o,
    output logic [rec_pkg::TS_W-1:0]        rd_stamp_o,
    output logic [rec_pkg::SMP_W-1:0]       rd_param_o,
    input  wire logic                       ev_rd_req_i,
    input  wire logic [rec_pkg::EIDX_W-1:0] ev_rd_idx_i,
    output logic                            ev_rd_valid_o,
    output logic [rec_pkg::TS_W+rec_pkg::CODE_W-1:0] ev_rd_data_o,
    output logic [rec_pkg::RIDX_W-1:0]      rec_count_o,
    output logic [rec_pkg::EIDX_W-1:0]      ev_count_o,
    output logic                            capturing_o,
    output logic                            overrun_o,
    output logic                            backlight_o,
    output logic                            tripped_o,
    output logic                            setting_mode_o,
    output logic [rec_pkg::SET_W-1:0]       setting_value_o
);
    localparam int unsigned SW = rec_pkg::SMP_W;
    localparam int unsigned EW = rec_pkg::TS_W + rec_pkg::CODE_W;

    function automatic logic [15:0] mod_add(input logic [15:0] a, input logic [15:0] b,
                                            input logic [15:0] lim);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        mod_add = (s >= {1'b0, lim}) ? 16'(s - {1'b0, lim}) : s[15:0];
    endfunction : mod_add

    function automatic logic [3:0] enc(input logic [8:0] v);
        enc = '0;
        for (int i = 0; i < 9; i++) begin
            if (v[i]) enc = 4'(i);
        end
    endfunction : enc

    // ==========================================================
    // synchronisers and timers
    logic [SW:0]                     adc_s1, adc_s2;
    logic                            adc_v3;
    logic [rec_pkg::KEY_N-1:0]       key_s1, key_s2, key_s3;
    logic [31:0]                     smp_div, ms_div;
    logic [rec_pkg::TS_W-1:0]        ts_ms;
    wire logic                       smp_tick, ms_tick, adc_new;

    assign smp_tick = (smp_div == 32'(SAMPLE_CYC - 1));
    assign ms_tick  = (ms_div == 32'(STAMP_CYC - 1));
    assign adc_new  = adc_s2[SW] & ~adc_v3;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            adc_s1 <= '0; adc_s2 <= '0; adc_v3 <= 1'b0;
            key_s1 <= '0; key_s2 <= '0; key_s3 <= '0;
            smp_div <= '0; ms_div <= '0; ts_ms <= '0; sample_req_o <= 1'b0;
        end else begin
            adc_s1 <= {adc_valid_i, adc_data_i};
            adc_s2 <= adc_s1;
            adc_v3 <= adc_s2[SW];
            key_s1 <= key_i;
            key_s2 <= key_s1;
            key_s3 <= key_s2;
            smp_div <= smp_tick ? '0 : smp_div + 32'h1;     // see R01
            sample_req_o <= smp_tick;                       // see R01
            ms_div <= ms_tick ? '0 : ms_div + 32'h1;        // see R06
            if (time_load_i) ts_ms <= time_value_i;
            else if (ms_tick) ts_ms <= ts_ms + 32'h1;       // see R06
        end
    end

    // ==========================================================
    // sample buffer; reads own the record memory, so they stall the drain
    stream_if #(.W(SW)) fifo_in ();
    stream_if #(.W(SW)) fifo_out ();
    assign fifo_in.valid  = adc_new;
    assign fifo_in.data   = adc_s2[SW-1:0];                 // see R02
    assign fifo_out.ready = ~|rd_req_i;

    sample_fifo #(.WIDTH(SW), .DEPTH(rec_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .in_s   (fifo_in),
        .out_s  (fifo_out)
    );

    // ==========================================================
    // waveform capture; each slot is a ring, so pre-trigger samples are
    // kept for free. a trip right after a capture gets a short pre window.
    logic [SW-1:0]                 wave_mem [rec_pkg::REC_NUM][rec_pkg::REC_SMP];
    logic [rec_pkg::SIDX_W-1:0]    end_ptr  [rec_pkg::REC_NUM];
    logic [rec_pkg::TS_W-1:0]      rec_stamp[rec_pkg::REC_NUM];
    logic [SW-1:0]                 rec_param[rec_pkg::REC_NUM];
    logic [rec_pkg::SIDX_W-1:0]    wr_ptr, post_cnt;
    logic [rec_pkg::RIDX_W-1:0]    wr_slot;
    wire logic                     wr_fire, trig, fin, rd_hit;
    wire logic [rec_pkg::SIDX_W-1:0] next_wr_ptr, rd_addr;
    wire logic [rec_pkg::RIDX_W-1:0] next_slot, rd_slot;

    assign wr_fire     = fifo_out.valid & fifo_out.ready;
    assign trig        = event_i[rec_pkg::EV_TRIP] & ~capturing_o;
    assign fin         = wr_fire & capturing_o
                       & (post_cnt == rec_pkg::SIDX_W'(rec_pkg::POST_SMP - 1));
    assign next_wr_ptr = rec_pkg::SIDX_W'(mod_add(16'(wr_ptr), 16'h0001,
                                                  16'(rec_pkg::REC_SMP)));
    assign next_slot   = rec_pkg::RIDX_W'(mod_add(16'(wr_slot), 16'h0001,
                                                  16'(rec_pkg::REC_NUM)));
    assign rd_slot     = rec_pkg::RIDX_W'(mod_add(16'(wr_slot),
                         16'(rec_pkg::REC_NUM - 1) - 16'(rd_rec_i), 16'(rec_pkg::REC_NUM)));
    assign rd_addr     = rec_pkg::SIDX_W'(mod_add(16'(end_ptr[rd_slot]), 16'(rd_idx_i),
                                                  16'(rec_pkg::REC_SMP)));
    assign rd_hit      = (rd_rec_i < rec_count_o);

    always_ff @(posedge clk_i) begin
        if (wr_fire) wave_mem[wr_slot][wr_ptr] <= fifo_out.data;   // see R02
        if (fin) end_ptr[wr_slot] <= next_wr_ptr;                  // see R03
        if (trig) begin
            rec_stamp[wr_slot] <= ts_ms;                           // see R05
            rec_param[wr_slot] <= fault_param_i;                   // see R05
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0; post_cnt <= '0; wr_slot <= '0;
            capturing_o <= 1'b0; rec_count_o <= '0; overrun_o <= 1'b0;
        end else begin
            if (wr_fire) wr_ptr <= next_wr_ptr;
            if (trig) capturing_o <= 1'b1;                         // see R03
            else if (fin) capturing_o <= 1'b0;
            if (trig) post_cnt <= '0;
            else if (wr_fire && capturing_o) post_cnt <= post_cnt + 11'h001;
            if (fin) wr_slot <= next_slot;                         // see R04
            if (fin && rec_count_o != rec_pkg::RIDX_W'(rec_pkg::REC_NUM))
                rec_count_o <= rec_count_o + 8'h01;                // see R04
            overrun_o <= overrun_o | (adc_new & ~fifo_in.ready);
        end
    end

    // ==========================================================
    // readout, front port wins over rear; answer one cycle later
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_valid_o <= '0; rd_data_o <= '0; rd_stamp_o <= '0; rd_param_o <= '0;
        end else begin
            rd_valid_o <= {rd_req_i[1] & ~rd_req_i[0], rd_req_i[0]};  // see R11
            rd_data_o  <= rd_hit ? wave_mem[rd_slot][rd_addr] : '0;  // see R11
            rd_stamp_o <= rd_hit ? rec_stamp[rd_slot] : '0;
            rd_param_o <= rd_hit ? rec_param[rd_slot] : '0;
        end
    end

    // ==========================================================
    // keypad and operating mode
    rec_pkg::mode_e                mode, next_mode;
    logic [rec_pkg::BL_W-1:0]      bl_cnt;
    wire logic [rec_pkg::KEY_N-1:0] press;
    wire logic                     menu, inc, dec, rst_ev, set_ev;
    wire logic [rec_pkg::BL_W-1:0] next_bl;
    wire logic [rec_pkg::SET_W-1:0] next_set;

    assign press  = key_s2 & ~key_s3;
    assign menu   = press[rec_pkg::KEY_MENU];
    assign inc    = press[rec_pkg::KEY_INC];
    assign dec    = press[rec_pkg::KEY_DEC];
    assign rst_ev = (mode == rec_pkg::ST_TRIPPED) & menu;                  // see R09
    assign set_ev = (mode == rec_pkg::ST_SETTING) & (inc ^ dec);
    assign next_set = (set_ev & inc & (setting_value_o != rec_pkg::SET_MAX))
                    ? setting_value_o + 8'h01                              // see R10
                    : (set_ev & dec & (setting_value_o != rec_pkg::SET_MIN))
                    ? setting_value_o - 8'h01 : setting_value_o;           // see R10
    assign next_bl = (|press) ? backlight_time_i                           // see R08
                   : (ms_tick && bl_cnt != '0) ? bl_cnt - 16'h0001 : bl_cnt;

    always_comb begin
        case (mode)
            rec_pkg::ST_NORMAL:  next_mode = event_i[rec_pkg::EV_TRIP] ? rec_pkg::ST_TRIPPED
                                           : menu ? rec_pkg::ST_SETTING : rec_pkg::ST_NORMAL;
            rec_pkg::ST_SETTING: next_mode = event_i[rec_pkg::EV_TRIP] ? rec_pkg::ST_TRIPPED
                                           : menu ? rec_pkg::ST_NORMAL : rec_pkg::ST_SETTING;
            rec_pkg::ST_TRIPPED: next_mode = menu ? rec_pkg::ST_NORMAL     // see R09
                                                  : rec_pkg::ST_TRIPPED;
            default:             next_mode = rec_pkg::ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mode <= rec_pkg::ST_NORMAL; bl_cnt <= '0; backlight_o <= 1'b0;
            tripped_o <= 1'b0; setting_mode_o <= 1'b0; setting_value_o <= '0;
        end else begin
            mode            <= next_mode;
            tripped_o       <= (next_mode == rec_pkg::ST_TRIPPED);
            setting_mode_o  <= (next_mode == rec_pkg::ST_SETTING);
            setting_value_o <= next_set;
            bl_cnt          <= next_bl;
            backlight_o     <= (next_bl != '0);                            // see R08
        end
    end

    // ==========================================================
    // event log; pending bits hold bursts, set wins over the clear
    logic [EW-1:0]                 ev_mem [rec_pkg::EV_NUM];
    logic [rec_pkg::EV_N-1:0]      pend;
    logic [rec_pkg::EIDX_W-1:0]    ev_wr;
    wire logic [rec_pkg::EV_N-1:0] ev_all, pend_low;
    wire logic                     ev_log;
    wire logic [rec_pkg::EIDX_W-1:0] ev_rd_addr;

    assign ev_all   = event_i | ({rec_pkg::EV_N{rst_ev}} & rec_pkg::EVM_RESET)
                    | ({rec_pkg::EV_N{set_ev}} & rec_pkg::EVM_SETTING);      // see R07
    assign pend_low = pend & (~pend + rec_pkg::EV_N'(1));
    assign ev_log   = |pend;
    assign ev_rd_addr = rec_pkg::EIDX_W'(mod_add(16'(ev_wr),
                        16'(rec_pkg::EV_NUM - 1) - 16'(ev_rd_idx_i), 16'(rec_pkg::EV_NUM)));

    always_ff @(posedge clk_i) begin
        if (ev_log) ev_mem[ev_wr] <= {ts_ms, enc(pend_low)};              // see R06
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pend <= '0; ev_wr <= '0; ev_count_o <= '0;
            ev_rd_valid_o <= 1'b0; ev_rd_data_o <= '0;
        end else begin
            pend <= (pend & ~pend_low) | ev_all;                             // see R07
            if (ev_log) ev_wr <= rec_pkg::EIDX_W'(mod_add(16'(ev_wr), 16'h0001,
                                     16'(rec_pkg::EV_NUM)));                       // see R12
            if (ev_log && ev_count_o != rec_pkg::EIDX_W'(rec_pkg::EV_NUM))
                ev_count_o <= ev_count_o + 13'h0001;                         // see R06
            ev_rd_valid_o <= ev_rd_req_i & (ev_rd_idx_i < ev_count_o);
            ev_rd_data_o  <= ev_mem[ev_rd_addr];
        end
    end

    // ==========================================================
    // checks
    logic [31:0] req_gap;
    logic        req_seen;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            req_gap <= '0; req_seen <= 1'b0;
        end else begin
            req_gap  <= sample_req_o ? '0 : req_gap + 32'h1;
            req_seen <= req_seen | sample_req_o;
        end
    end

    sample_rate_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R01
        (sample_req_o && req_seen) |-> req_gap == 32'(SAMPLE_CYC - 1))
        else $error("sample request spacing wrong");
    sample_word_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R02
        adc_new |-> fifo_in.data == adc_s2[SW-1:0]) else $error("sample word altered");
    post_window_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R03
        trig |=> capturing_o && post_cnt == '0) else $error("capture not started");
    record_ring_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R04
        fin && $past(wr_slot) == wr_slot |=> wr_slot == $past(next_slot) && !capturing_o)
        else $error("record slot not advanced");
    fault_stamp_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R05
        trig |=> rec_stamp[$past(wr_slot)] == $past(ts_ms)) else $error("fault stamp lost");
    event_count_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R06
        ev_log && ev_count_o != 13'(rec_pkg::EV_NUM) |=> ev_count_o == $past(ev_count_o) + 1)
        else $error("event count wrong");
    event_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R07
        (|ev_all) |=> (|pend)) else $error("event dropped");
    backlight_on_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R08
        (|press) && backlight_time_i != '0 |=> backlight_o) else $error("backlight stays off");
    trip_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R09
        rst_ev |=> !tripped_o && mode == rec_pkg::ST_NORMAL) else $error("trip not reset");
    setting_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R10
        set_ev && inc && setting_value_o != rec_pkg::SET_MAX
        |=> setting_value_o == $past(setting_value_o) + 8'h01) else $error("setting not raised");
    rear_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R11
        rd_req_i == 2'b10 |=> rd_valid_o == 2'b10) else $error("rear read not answered");
    event_wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R12
        ev_log && ev_wr == 13'(rec_pkg::EV_NUM - 1) |=> ev_wr == '0) else $error("log no wrap");

    cover_capture: cover property (@(posedge clk_i) disable iff (!rstn_i) fin);
    cover_log_full: cover property (@(posedge clk_i) disable iff (!rstn_i)
        ev_count_o == 13'(rec_pkg::EV_NUM));
    cover_trip_reset: cover property (@(posedge clk_i) disable iff (!rstn_i) rst_ev);
endmodule : fault_event_recorder

// ==== verilog/rec_pkg.sv ====
// constants, widths and states shared by the fault and event recorder
// assumes a 100 MHz system clock and a 50 Hz power system
package rec_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned LINE_HZ       = 50;
    localparam int unsigned SMP_PER_CYC   = 32;
    localparam int unsigned SAMPLE_NS     = 1000000000 / (LINE_HZ * SMP_PER_CYC);
    localparam int unsigned SAMPLE_CYC    = SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned STAMP_NS      = 1000000;
    localparam int unsigned STAMP_CYC     = STAMP_NS / CLK_PERIOD_NS;
    // ==========================================================
    // waveform records
    localparam int unsigned SMP_W    = 16;
    localparam int unsigned PRE_CYC  = 45;
    localparam int unsigned POST_CYC = 5;
    localparam int unsigned REC_SMP  = (PRE_CYC + POST_CYC) * SMP_PER_CYC;
    localparam int unsigned POST_SMP = POST_CYC * SMP_PER_CYC;
    localparam int unsigned REC_NUM  = 200;
    localparam int unsigned SIDX_W   = 11;
    localparam int unsigned RIDX_W   = 8;
    localparam int unsigned FIFO_DEPTH = 4;
    // ==========================================================
    // event log
    localparam int unsigned EV_NUM  = 5000;
    localparam int unsigned EIDX_W  = 13;
    localparam int unsigned TS_W    = 32;
    localparam int unsigned CODE_W  = 4;
    localparam int unsigned EV_N    = 9;
    localparam int unsigned EV_TRIP = 0;
    localparam logic [8:0]  EVM_RESET   = 9'h008;
    localparam logic [8:0]  EVM_SETTING = 9'h080;
    // ==========================================================
    // keypad
    localparam int unsigned KEY_N    = 4;
    localparam int unsigned KEY_MENU = 0;
    localparam int unsigned KEY_INC  = 1;
    localparam int unsigned KEY_DEC  = 2;
    localparam int unsigned SET_W    = 8;
    localparam int unsigned BL_W     = 16;
    localparam logic [7:0]  SET_MAX  = 8'hFF;
    localparam logic [7:0]  SET_MIN  = 8'h00;

    typedef enum logic [2:0] {
        ST_NORMAL  = 3'h1,
        ST_SETTING = 3'h2,
        ST_TRIPPED = 3'h4
    } mode_e;
endpackage : rec_pkg

// ==== verilog/stream_if.sv ====
// valid/ready word stream between the recorder's own modules
// assumes both ends share one clock
`timescale 1ns/1ps
interface stream_if #(parameter int unsigned W = 16) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== verilog/sample_fifo.sv ====
// small first-in first-out buffer for converter samples
// assumes the source honours ready and the sink may stall at will
`timescale 1ns/1ps
module sample_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    stream_if.snk     in_s,
    stream_if.src     out_s
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire logic        push;
    wire logic        pop;

    // ==========================================================
    // handshakes
    assign in_s.ready  = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data  = mem[rd_ptr];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ==========================================================
    // checks
    fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
    cover_fifo_full: cover property (@(posedge clk_i) disable iff (!rstn_i)
        !in_s.ready);
endmodule : sample_fifo

// ==== dv/adc_model.sv ====
// converter model: answers each sample request with a held 16 bit word
// assumes requests come as one-cycle pulses on clk_i
`timescale 1ns/1ps
module adc_model (
    input  wire logic                      clk_i,
    input  wire logic                      sample_req_i,
    output logic                           adc_valid_o,
    output logic [rec_pkg::SMP_W-1:0]      adc_data_o
);
    logic [rec_pkg::SMP_W-1:0] word;
    int                        hold;
    initial begin
        adc_valid_o = 1'b0;
        adc_data_o  = 16'h0000;
        word        = 16'h0100;
        hold        = 0;
    end
    // data stands still while valid is high, then churns so stale data never matches
    always @(posedge clk_i) begin
        if (sample_req_i) begin
            hold <= 6;
            word <= word + 16'h0001;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
        adc_valid_o <= (hold > 1);
        adc_data_o  <= (hold > 0) ? word : ~adc_data_o;
    end
endmodule : adc_model

// ==== dv/fault_event_recorder_test.sv ====
// self-checking bench for the fault and event recorder
// assumes shortened sample and millisecond counts set below
`timescale 1ns/1ps
module fault_event_recorder_test;
    localparam int unsigned SCYC = 20;
    logic clk_i = 0, rstn_i = 0, req, av, tl = 0, evr = 0;
    logic [15:0] ad, fp = 16'h0000, bt = 16'h0003, rdd, rdp;
    logic [8:0] ev = 9'h000;
    logic [3:0] key = 4'h0;
    logic [1:0] rr = 2'b00, rv;
    logic [7:0] rrec = 8'h00, rc, sv;
    logic [10:0] ridx = 11'h000;
    logic [12:0] eidx = 13'h0000, ec;
    logic [35:0] evd;
    logic [31:0] rds, tv = 32'h0000_0000;
    logic evv, cap, ovr, bl, tr, sm;
    int failures = 0, n_compared = 0, k;
    always #5 clk_i = ~clk_i;
    adc_model PARTNER (.clk_i(clk_i), .sample_req_i(req), .adc_valid_o(av), .adc_data_o(ad));
    fault_event_recorder #(.SAMPLE_CYC(SCYC), .STAMP_CYC(10)) DUT (.clk_i(clk_i),
        .rstn_i(rstn_i), .sample_req_o(req), .adc_valid_i(av), .adc_data_i(ad), .event_i(ev),
        .fault_param_i(fp), .time_load_i(tl), .time_value_i(tv), .key_i(key),
        .backlight_time_i(bt), .rd_req_i(rr), .rd_rec_i(rrec), .rd_idx_i(ridx),
        .rd_valid_o(rv), .rd_data_o(rdd), .rd_stamp_o(rds), .rd_param_o(rdp),
        .ev_rd_req_i(evr), .ev_rd_idx_i(eidx), .ev_rd_valid_o(evv), .ev_rd_data_o(evd),
        .rec_count_o(rc), .ev_count_o(ec), .capturing_o(cap), .overrun_o(ovr),
        .backlight_o(bl), .tripped_o(tr), .setting_mode_o(sm), .setting_value_o(sv));
    // ==========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic press(input int b);
        key[b] = 1'b1;
        tick(6);
        key[b] = 1'b0;
        tick(6);
    endtask : press
    task automatic complete_run;
        $display("counts: compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // ==========================================================
    // scenarios
    task automatic t_rate;
        k = 0;
        repeat (10 * SCYC) begin tick(1); if (req === 1'b1) k++; end
        chk(k == 10, "sample request rate");
        chk(ovr === 1'b0, "overrun with prompt converter");
        $display("rate done");
    endtask : t_rate
    task automatic t_events;
        for (int b = 0; b < 9; b++) begin
            if (b != 0) begin ev = 9'h001 << b; tick(1); ev = 9'h000; tick(1); end
        end
        tick(12);
        chk(ec === 13'h0008, "event count");
        evr = 1'b1; eidx = 13'h0000; tick(1);
        chk(evv === 1'b1 && evd[3:0] === 4'h8, "newest event code");
        eidx = 13'h0007; tick(1);
        chk(evv === 1'b1 && evd[3:0] === 4'h1, "oldest event code");
        eidx = 13'h0008; tick(1);
        chk(evv === 1'b0, "event past count");
        evr = 1'b0; tick(1);
        $display("events done");
    endtask : t_events
    task automatic t_keys;
        press(rec_pkg::KEY_MENU);
        chk(sm === 1'b1 && bl === 1'b1, "setting mode and backlight");
        press(rec_pkg::KEY_DEC);
        chk(sv === 8'h00, "decrement saturates at zero");
        press(rec_pkg::KEY_INC); press(rec_pkg::KEY_INC); press(rec_pkg::KEY_DEC);
        chk(sv === 8'h01, "increment and decrement");
        press(rec_pkg::KEY_MENU);
        chk(sm === 1'b0, "back to normal");
        tick(100);
        chk(bl === 1'b0, "backlight times out");
        $display("keys done");
    endtask : t_keys
    task automatic t_trip;
        logic [15:0] exp_w;
        tv = 32'h0012_3400; tl = 1'b1; tick(1); tl = 1'b0;
        fp = 16'hA5C3; ev = 9'h001; tick(1); ev = 9'h000; fp = 16'h0000; tick(2);
        chk(tr === 1'b1 && cap === 1'b1, "trip starts capture");
        k = 0;
        while (cap === 1'b1 && k < 8000) begin tick(1); k++; end
        exp_w = PARTNER.word;
        chk(k > 160 * SCYC - 40 && k < 160 * SCYC + 60, "post trigger length");
        chk(rc === 8'h01, "record stored");
        rrec = 8'h00; ridx = 11'h63F; rr = 2'b11; tick(1);
        chk(rv === 2'b01 && rdp === 16'hA5C3, "front read wins");
        rr = 2'b10; tick(1);
        chk(rv === 2'b10 && rdp === 16'hA5C3 && rdd === exp_w && rds === tv, "rear read");
        rrec = 8'h01; tick(1);
        chk(rdp === 16'h0000, "absent record reads zero");
        rr = 2'b00; tick(1);
        evr = 1'b1; eidx = 13'h0000; tick(1);
        chk(evv === 1'b1 && evd[3:0] === 4'h0 && evd[35:4] - tv <= 32'h1, "trip stamp");
        evr = 1'b0;
        press(rec_pkg::KEY_MENU);
        chk(tr === 1'b0 && sm === 1'b0, "menu clears trip");
        $display("trip done");
    endtask : t_trip
    task automatic t_wrap;
        ev = 9'h004; tick(5010); ev = 9'h000; tick(2);
        chk(ec === 13'h1388, "event count saturates");
        evr = 1'b1; eidx = 13'h1387; tick(1);
        chk(evv === 1'b1 && evd[3:0] === 4'h2, "oldest entry overwritten");
        evr = 1'b0; tick(1);
        $display("wrap done");
    endtask : t_wrap
    initial begin
        tick(12);
        rstn_i = 1'b1;
        tick(1);
        chk(tr === 1'b0 && rc === 8'h00 && ec === 13'h0000, "reset state");
        t_rate();
        t_events();
        t_keys();
        t_trip();
        t_wrap();
        complete_run();
    end
    // watchdog sized from the capture span and log fill plus margin
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        complete_run();
    end
endmodule : fault_event_recorder_test
